// file: core/suart_pkg.sv
/*
  Package for the serial port engine: register offsets, control field
  positions, reset values, mode codes, timing counts and state types.
  Assumes a single 200 MHz system clock that also serves as CPU clock.
*/
`default_nettype none
package suart_pkg;

  localparam int CLK_MHZ = 200;
  localparam int ADDR_W = 2;

  // register offsets
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [1:0] OFS_PWR = 2'h2;

  // control and power register field positions
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MPF = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TX9 = 3;
  localparam int BIT_RX9 = 2;
  localparam int BIT_TXDONE = 1;
  localparam int BIT_RXDONE = 0;
  localparam int BIT_DOUBLER = 7;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic RST_DOUBLER = 1'b0;

  // serial modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;

  // machine cycle: six states, one clock each
  localparam logic [2:0] MC_LAST = 3'h5;
  localparam logic [2:0] MC_S1 = 3'h0;
  localparam logic [2:0] MC_S5 = 3'h4;
  localparam logic [2:0] MC_S6 = 3'h5;

  // oversampling counter
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_SAMPLE_A = 4'h7;
  localparam logic [3:0] OS_SAMPLE_B = 4'h8;
  localparam logic [3:0] OS_SAMPLE_C = 4'h9;

  // shift counts
  localparam logic [3:0] SH_LAST_8 = 4'h7;
  localparam logic [3:0] SH_LAST_9 = 4'h8;
  localparam logic [3:0] RX_LAST_IDX = 4'h9;
  localparam logic [7:0] RX0_PRELOAD = 8'hfe;
  localparam logic [8:0] RXA_PRELOAD = 9'h1ff;

  typedef enum logic [1:0] {
    SUART_TX_IDLE = 2'b00,
    SUART_TX_ARM = 2'b01,
    SUART_TX_START = 2'b11,
    SUART_TX_DATA = 2'b10
  } suart_tx_st_t;

  typedef enum logic [1:0] {
    SUART_RX_HUNT = 2'b00,
    SUART_RX_ARM = 2'b01,
    SUART_RX_SHIFT = 2'b11,
    SUART_RX_BITS = 2'b10
  } suart_rx_st_t;

endpackage
`default_nettype wire

// file: core/suart_core.sv
/*
  Serial port engine: shift-register mode, 8-bit and 9-bit asynchronous
  modes, with control, data and power registers on a plain register port.
  Assumes the baud timer lives outside and delivers a one-cycle overflow
  pulse on the system clock; all register strobes are one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none

module suart_core
  import suart_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic baud_timer_ovf_i,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o
);

  logic [1:0] mode_reg;
  logic mp_filter_reg;
  logic rx_en_reg;
  logic tx_ninth_reg;
  logic rx_ninth_reg;
  logic tx_done_reg;
  logic rx_done_reg;
  logic baud_doubler_reg;
  logic [7:0] rx_buf_reg;

  logic [2:0] mc_reg;
  logic os_half_reg;
  logic [3:0] os_cnt_reg;
  logic rxd_s1_reg, rxd_s2_reg, rxd_s3_reg, rxd_lvl_reg;
  logic prev_lvl_reg;

  suart_tx_st_t tx_st_reg;
  logic [8:0] tx_sr_reg;
  logic [3:0] tx_shifts_reg;
  // set when the request missed the current S6, so one whole machine cycle passes
  logic tx_skip_reg;

  suart_rx_st_t rx_st_reg;
  logic [7:0] rx0_sr_reg;
  logic [8:0] rxa_sr_reg;
  logic [3:0] rx_idx_reg;
  logic rx_skip_reg;
  logic samp_a_reg, samp_b_reg;
  logic rx0_samp_reg;

  logic wr_ctrl, wr_data, wr_pwr;
  logic is_shift_mode;
  logic s6, os_src, os_tick, roll;
  logic rx_edge, maj;
  logic tx_done_set, rx_done_set;
  logic rx_load;
  logic [7:0] rx_load_data;
  logic rx_ninth_set, rx_ninth_val;
  logic [7:0] rx0_next;
  logic [7:0] rx0_rev;
  logic tx_last;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  assign wr_data = reg_wr_i && (reg_addr_i == OFS_DATA);
  assign wr_pwr = reg_wr_i && (reg_addr_i == OFS_PWR);
  assign is_shift_mode = (mode_reg == MODE_SHIFT);
  assign s6 = (mc_reg == MC_S6);

  // machine cycle states, S1 = 0 .. S6 = 5
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mc_reg <= MC_S1;
    end else if (mc_reg == MC_LAST) begin
      mc_reg <= MC_S1;
    end else begin
      mc_reg <= mc_reg + 3'h1;
    end
  end

  // oversampling tick source
  always_comb begin
    os_src = (mode_reg == MODE_FIXED9) ? 1'b1 : baud_timer_ovf_i;
    os_tick = os_src && (baud_doubler_reg || os_half_reg);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      os_half_reg <= 1'b0;
    end else if (os_src) begin
      os_half_reg <= ~os_half_reg;
    end
  end

  // pin synchroniser; level accepted when stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      rxd_s3_reg <= 1'b1;
      rxd_lvl_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= rxd_i;
      rxd_s2_reg <= rxd_s1_reg;
      rxd_s3_reg <= rxd_s2_reg;
      if (rxd_s2_reg == rxd_s3_reg) begin
        rxd_lvl_reg <= rxd_s3_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prev_lvl_reg <= 1'b1;
    end else if (os_tick) begin
      prev_lvl_reg <= rxd_lvl_reg;
    end
  end

  assign rx_edge = os_tick && prev_lvl_reg && !rxd_lvl_reg && !is_shift_mode
    && rx_en_reg && (rx_st_reg == SUART_RX_HUNT);
  assign roll = os_tick && (os_cnt_reg == OS_LAST);

  // divide-by-16 counter, realigned by a start edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      os_cnt_reg <= 4'h0;
    end else if (rx_edge) begin
      os_cnt_reg <= 4'h0;
    end else if (os_tick) begin
      os_cnt_reg <= os_cnt_reg + 4'h1;
    end
  end

  // ---------------- transmit ----------------
  always_comb begin
    if (mode_reg == MODE_FIXED9 || mode_reg == MODE_VAR9) begin
      tx_last = (tx_shifts_reg == SH_LAST_9);
    end else begin
      tx_last = (tx_shifts_reg == SH_LAST_8);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_st_reg <= SUART_TX_IDLE;
      tx_sr_reg <= 9'h1ff;
      tx_shifts_reg <= 4'h0;
      tx_skip_reg <= 1'b0;
    end else if (wr_data) begin
      tx_st_reg <= SUART_TX_ARM;
      tx_skip_reg <= !s6;
      tx_shifts_reg <= 4'h0;
      if (mode_reg == MODE_FIXED9 || mode_reg == MODE_VAR9) begin
        tx_sr_reg <= {tx_ninth_reg, reg_wdata_i};
      end else begin
        tx_sr_reg <= {1'b1, reg_wdata_i};
      end
    end else begin
      case (tx_st_reg)
        SUART_TX_IDLE: begin
          tx_shifts_reg <= 4'h0;
        end
        SUART_TX_ARM: begin
          if (is_shift_mode && s6 && tx_skip_reg) begin
            tx_skip_reg <= 1'b0;
          end else if (is_shift_mode && s6) begin
            tx_st_reg <= SUART_TX_DATA;
          end else if (!is_shift_mode && roll) begin
            tx_st_reg <= SUART_TX_START;
          end
        end
        SUART_TX_START: begin
          if (roll) begin
            tx_st_reg <= SUART_TX_DATA;
          end
        end
        SUART_TX_DATA: begin
          if ((is_shift_mode && s6) || (!is_shift_mode && roll)) begin
            if (!is_shift_mode && mode_reg != MODE_UART8 && tx_shifts_reg == 4'h0) begin
              tx_sr_reg <= {1'b1, tx_sr_reg[8:1]};
            end else begin
              tx_sr_reg <= {1'b0, tx_sr_reg[8:1]};
            end
            tx_shifts_reg <= tx_shifts_reg + 4'h1;
            if (tx_last) begin
              tx_st_reg <= SUART_TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_reg <= SUART_TX_IDLE;
        end
      endcase
    end
  end

  assign tx_done_set = (tx_st_reg == SUART_TX_DATA) && tx_last && !wr_data
    && ((is_shift_mode && s6) || (!is_shift_mode && roll));

  // ---------------- receive ----------------
  assign maj = (samp_a_reg & samp_b_reg) | (samp_a_reg & rxd_lvl_reg)
    | (samp_b_reg & rxd_lvl_reg);
  assign rx0_next = {rx0_sr_reg[6:0], rx0_samp_reg};

  // first bit in ends at the top; reverse so the buffer reads LSB first
  always_comb begin
    rx0_rev = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rx0_rev[i] = rx0_next[7-i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
    end else if (os_tick && os_cnt_reg == OS_SAMPLE_A) begin
      samp_a_reg <= rxd_lvl_reg;
    end else if (os_tick && os_cnt_reg == OS_SAMPLE_B) begin
      samp_b_reg <= rxd_lvl_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx0_samp_reg <= 1'b1;
    end else if (mc_reg == MC_S5) begin
      rx0_samp_reg <= rxd_lvl_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_st_reg <= SUART_RX_HUNT;
      rx_skip_reg <= 1'b0;
      rx0_sr_reg <= RX0_PRELOAD;
      rxa_sr_reg <= RXA_PRELOAD;
      rx_idx_reg <= 4'h0;
    end else begin
      case (rx_st_reg)
        SUART_RX_HUNT: begin
          if (is_shift_mode && rx_en_reg && !rx_done_reg) begin
            rx_st_reg <= SUART_RX_ARM;
            rx_skip_reg <= !s6;
          end else if (rx_edge) begin
            rx_st_reg <= SUART_RX_BITS;
            rxa_sr_reg <= RXA_PRELOAD;
            rx_idx_reg <= 4'h0;
          end
        end
        SUART_RX_ARM: begin
          if (!is_shift_mode) begin
            rx_st_reg <= SUART_RX_HUNT;
          end else if (s6 && rx_skip_reg) begin
            rx_skip_reg <= 1'b0;
          end else if (s6) begin
            rx0_sr_reg <= RX0_PRELOAD;
            rx_st_reg <= SUART_RX_SHIFT;
          end
        end
        SUART_RX_SHIFT: begin
          if (!is_shift_mode) begin
            rx_st_reg <= SUART_RX_HUNT;
          end else if (s6) begin
            rx0_sr_reg <= rx0_next;
            if (!rx0_sr_reg[7]) begin
              rx_st_reg <= SUART_RX_HUNT;
            end
          end
        end
        SUART_RX_BITS: begin
          if (is_shift_mode) begin
            rx_st_reg <= SUART_RX_HUNT;
          end else if (os_tick && os_cnt_reg == OS_SAMPLE_C) begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && maj) begin
              rx_st_reg <= SUART_RX_HUNT;
            end else if (rx_idx_reg == RX_LAST_IDX) begin
              rx_st_reg <= SUART_RX_HUNT;
            end else begin
              rxa_sr_reg <= {maj, rxa_sr_reg[8:1]};
            end
          end
        end
        default: begin
          rx_st_reg <= SUART_RX_HUNT;
        end
      endcase
    end
  end

  // load decision, taken at the eighth shift-mode bit or at async bit index 9 (8-bit stop bit, 9-bit ninth data bit)
  always_comb begin
    rx_load = 1'b0;
    rx_load_data = rxa_sr_reg[8:1];
    rx_ninth_set = 1'b0;
    rx_ninth_val = maj;
    if (rx_st_reg == SUART_RX_SHIFT && is_shift_mode && s6 && !rx0_sr_reg[7]) begin
      rx_load = 1'b1;
      rx_load_data = rx0_rev;
    end else if (rx_st_reg == SUART_RX_BITS && !is_shift_mode && os_tick
        && os_cnt_reg == OS_SAMPLE_C && rx_idx_reg == RX_LAST_IDX) begin
      rx_load = !rx_done_reg && (!mp_filter_reg || maj);
      rx_ninth_set = rx_load;
    end
  end

  assign rx_done_set = rx_load;

  // ---------------- registers ----------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_reg <= RST_CTRL[BIT_MODE_HI:BIT_MODE_LO];
      mp_filter_reg <= RST_CTRL[BIT_MPF];
      rx_en_reg <= RST_CTRL[BIT_REN];
      tx_ninth_reg <= RST_CTRL[BIT_TX9];
    end else if (wr_ctrl) begin
      mode_reg <= reg_wdata_i[BIT_MODE_HI:BIT_MODE_LO];
      mp_filter_reg <= reg_wdata_i[BIT_MPF];
      rx_en_reg <= reg_wdata_i[BIT_REN];
      tx_ninth_reg <= reg_wdata_i[BIT_TX9];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_done_reg <= RST_CTRL[BIT_TXDONE];
      rx_done_reg <= RST_CTRL[BIT_RXDONE];
    end else begin
      if (tx_done_set) begin
        tx_done_reg <= 1'b1;
      end else if (wr_ctrl) begin
        tx_done_reg <= reg_wdata_i[BIT_TXDONE];
      end
      if (rx_done_set) begin
        rx_done_reg <= 1'b1;
      end else if (wr_ctrl) begin
        rx_done_reg <= reg_wdata_i[BIT_RXDONE];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_ninth_reg <= RST_CTRL[BIT_RX9];
    end else if (rx_ninth_set) begin
      rx_ninth_reg <= rx_ninth_val;
    end else if (wr_ctrl) begin
      rx_ninth_reg <= reg_wdata_i[BIT_RX9];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_buf_reg <= RST_DATA;
    end else if (rx_load) begin
      rx_buf_reg <= rx_load_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      baud_doubler_reg <= RST_DOUBLER;
    end else if (wr_pwr) begin
      baud_doubler_reg <= reg_wdata_i[BIT_DOUBLER];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CTRL: begin
          reg_rdata_o <= {mode_reg, mp_filter_reg, rx_en_reg, tx_ninth_reg,
            rx_ninth_reg, tx_done_reg, rx_done_reg};
        end
        OFS_DATA: begin
          reg_rdata_o <= rx_buf_reg;
        end
        OFS_PWR: begin
          reg_rdata_o <= {baud_doubler_reg, 7'h00};
        end
        default: begin
          reg_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // ---------------- pins ----------------
  // shift clock computed for the next machine state so the pin lands on time
  logic sclk_next_low;
  logic shift_busy;
  assign sclk_next_low = (mc_reg == 3'h1) || (mc_reg == 3'h2) || (mc_reg == 3'h3);
  assign shift_busy = is_shift_mode
    && (tx_st_reg == SUART_TX_DATA || rx_st_reg == SUART_RX_SHIFT);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      txd_o <= 1'b1;
    end else if (shift_busy) begin
      txd_o <= !sclk_next_low;
    end else if (!is_shift_mode && tx_st_reg == SUART_TX_START) begin
      txd_o <= 1'b0;
    end else if (!is_shift_mode && tx_st_reg == SUART_TX_DATA) begin
      txd_o <= tx_sr_reg[0];
    end else begin
      txd_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rxd_o <= 1'b1;
      rxd_oe_o <= 1'b0;
    end else begin
      rxd_o <= tx_sr_reg[0];
      rxd_oe_o <= is_shift_mode && (tx_st_reg == SUART_TX_DATA);
    end
  end

endmodule

`default_nettype wire

// file: dv/suart_core_assertions.sv
/*
  Port checker for the serial port engine, bound into suart_core.
  Assumes one clock domain and register strobes that never overlap.
*/
`timescale 1ns/1ps
`default_nettype none
module suart_chk
  import suart_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic rxd_oe_o,
  input wire logic txd_o
);
  logic [1:0] mode_q;
  logic dbl_q;
  logic [7:0] oe_len;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // software view of mode and doubler
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_q <= MODE_SHIFT;
      dbl_q <= RST_DOUBLER;
    end else if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
      mode_q <= reg_wdata_i[BIT_MODE_HI:BIT_MODE_LO];
    end else if (reg_wr_i && reg_addr_i == OFS_PWR) begin
      dbl_q <= reg_wdata_i[BIT_DOUBLER];
    end
  end
  // length of one pin drive burst
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !rxd_oe_o) begin
      oe_len <= 8'h00;
    end else begin
      oe_len <= oe_len + 8'h01;
    end
  end
  sequence clk_low_phase;
    !txd_o [*3] ##1 txd_o;
  endsequence
  sequence ctrl_read;
    reg_rd_i && reg_addr_i == OFS_CTRL;
  endsequence
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_pwr_unused: assert property (reg_rd_i && reg_addr_i == OFS_PWR |=> reg_rdata_o[6:0] == 7'h00)
    else $error("power reg spare bits set");
  chk_doubler_echo: assert property (
    reg_rd_i && reg_addr_i == OFS_PWR |=> reg_rdata_o[BIT_DOUBLER] == dbl_q)
    else $error("doubler read back wrong");
  chk_mode_echo: assert property (ctrl_read |=> reg_rdata_o[7:6] == mode_q)
    else $error("mode read back wrong");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_oe_shift_only: assert property (rxd_oe_o |-> mode_q == MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  chk_shclk_low: assert property (mode_q == MODE_SHIFT && $fell(txd_o) |-> clk_low_phase)
    else $error("shift clock low phase not three cycles");
  chk_shclk_high: assert property (mode_q == MODE_SHIFT && $rose(txd_o) |-> txd_o [*3])
    else $error("shift clock high phase too short");
  chk_byte_len: assert property ($fell(rxd_oe_o) |-> oe_len inside {[8'h2a:8'h36]})
    else $error("shift transmit length wrong");
  chk_send_delay: assert property (
    mode_q == MODE_SHIFT && reg_wr_i && reg_addr_i == OFS_DATA |=> !rxd_oe_o [*6])
    else $error("shift send started before a full machine cycle");
endmodule
bind suart_core suart_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
`default_nettype wire

// file: dv/suart_node.sv
/*
  Remote serial node: async frame sender and receiver, shift peripheral.
  Assumes the bench resolves the data pin; released line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module suart_node (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic rxd_pin_i,
  output logic rxd_drv_o
);
  initial rxd_drv_o = 1'b1;
  // bit 0 first, one bit every bc clocks
  task automatic send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rxd_drv_o <= f[i];
      repeat (bc) @(posedge clk_i);
    end
    rxd_drv_o <= 1'b1;
  endtask
  // mid-bit sampling from the start edge
  task automatic recv(input int n, input int bc, output logic [10:0] f);
    f = 11'h000;
    @(negedge txd_i);
    repeat (bc / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = txd_i;
      repeat (bc) @(posedge clk_i);
    end
  endtask
  // next bit presented after each rising shift clock
  task automatic sh_send(input logic [7:0] d);
    logic [7:0] q;
    q = d;
    rxd_drv_o <= q[0];
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_i);
      q = {1'b1, q[7:1]};
      rxd_drv_o <= q[0];
    end
  endtask
  // data stable through the low phase
  task automatic sh_recv(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_i);
      d[i] = rxd_pin_i;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/tb_suart_core.sv
/*
  Self-checking bench for the serial port engine with a remote node.
  Assumes the checker binds itself; overflow pulses every second clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_suart_core
  import suart_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic baud_timer_ovf_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic rxd_o;
  logic rxd_oe_o;
  logic txd_o;
  logic node_rxd;
  wire rxd_pin = rxd_oe_o ? rxd_o : node_rxd;
  int err_total = 0;
  int checks_done = 0;
  suart_core dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .baud_timer_ovf_i(baud_timer_ovf_i), .rxd_i(rxd_pin),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
  suart_node node (.clk_i(clk_sys_i), .txd_i(txd_o), .rxd_pin_i(rxd_pin),
    .rxd_drv_o(node_rxd));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    baud_timer_ovf_i <= ~baud_timer_ovf_i;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [10:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = {3'h0, reg_rdata_o};
  endtask
  task automatic chk(input string n, input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [7:0] cw(input logic [1:0] m, input logic f, input logic en,
    input logic t9);
    return {m, f, en, t9, 3'h0};
  endfunction
  task automatic tally_and_finish();
    $display("Mismatches %0d in %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic t_regs();
    logic [10:0] d;
    rd(OFS_CTRL, d);
    chk("ctrl_reset", d, 11'h000);
    rd(OFS_DATA, d);
    chk("data_reset", d, 11'h000);
    wr(2'h3, 8'hff);
    rd(2'h3, d);
    chk("unmapped", d, 11'h000);
    wr(OFS_PWR, 8'hff);
    rd(OFS_PWR, d);
    chk("pwr_write", d, 11'h080);
  endtask
  task automatic t_shift_tx();
    logic [10:0] d;
    logic [7:0] v;
    wr(OFS_CTRL, cw(MODE_SHIFT, 1'b0, 1'b0, 1'b0));
    fork
      node.sh_recv(v);
      begin
        wr(OFS_DATA, 8'ha5);
        rd(OFS_CTRL, d);
      end
    join
    chk("sh_tx_early", d & 11'h002, 11'h000);
    chk("sh_tx_byte", {3'h0, v}, 11'h0a5);
    repeat (12) @(posedge clk_sys_i);
    rd(OFS_CTRL, d);
    chk("sh_tx_done", d & 11'h002, 11'h002);
  endtask
  task automatic t_shift_rx();
    logic [10:0] d;
    fork
      node.sh_send(8'h3c);
      wr(OFS_CTRL, cw(MODE_SHIFT, 1'b0, 1'b1, 1'b0));
    join
    repeat (12) @(posedge clk_sys_i);
    rd(OFS_DATA, d);
    chk("sh_rx_byte", d, 11'h03c);
    rd(OFS_CTRL, d);
    chk("sh_rx_done", d & 11'h001, 11'h001);
  endtask
  task automatic t_async_tx();
    logic [10:0] f;
    logic [10:0] d;
    logic [10:0] ex;
    logic [7:0] dt;
    logic [1:0] m;
    wr(OFS_PWR, 8'h80);
    for (int i = 1; i < 4; i++) begin
      m = 2'(i);
      dt = 8'h5a ^ 8'(i);
      ex = (m == MODE_UART8) ? {2'b01, dt, 1'b0} : {1'b1, m[0], dt, 1'b0};
      wr(OFS_CTRL, cw(m, 1'b0, 1'b0, m[0]));
      fork
        node.recv((m == MODE_UART8) ? 10 : 11, (m == MODE_FIXED9) ? 16 : 32, f);
        begin
          wr(OFS_DATA, dt);
          rd(OFS_CTRL, d);
        end
      join
      chk("tx_early", d & 11'h002, 11'h000);
      chk("tx_frame", f, ex);
      rd(OFS_CTRL, d);
      chk("tx_done", d & 11'h002, 11'h002);
    end
  endtask
  task automatic t_async_rx();
    logic [10:0] d;
    wr(OFS_PWR, 8'h00);
    wr(OFS_CTRL, cw(MODE_UART8, 1'b1, 1'b1, 1'b0));
    node.send({2'b00, 8'h11, 1'b0}, 10, 64);
    rd(OFS_CTRL, d);
    chk("bad_stop", d & 11'h001, 11'h000);
    node.send(11'h000, 1, 8);
    repeat (128) @(posedge clk_sys_i);
    node.send({2'b01, 8'h96, 1'b0}, 10, 64);
    rd(OFS_DATA, d);
    chk("rx_byte", d, 11'h096);
    rd(OFS_CTRL, d);
    chk("rx_flags", d & 11'h005, 11'h005);
    node.send({2'b01, 8'h69, 1'b0}, 10, 64);
    rd(OFS_DATA, d);
    chk("rx_full", d, 11'h096);
  endtask
  task automatic t_nine_rx();
    logic [10:0] d;
    wr(OFS_CTRL, cw(MODE_FIXED9, 1'b1, 1'b1, 1'b0));
    node.send({2'b10, 8'h33, 1'b0}, 11, 32);
    rd(OFS_CTRL, d);
    chk("nine_filter", d & 11'h001, 11'h000);
    node.send({2'b11, 8'hc3, 1'b0}, 11, 32);
    rd(OFS_DATA, d);
    chk("nine_byte", d, 11'h0c3);
    rd(OFS_CTRL, d);
    chk("nine_flags", d & 11'h005, 11'h005);
    wr(OFS_CTRL, cw(MODE_VAR9, 1'b0, 1'b1, 1'b0));
    node.send({2'b10, 8'h42, 1'b0}, 11, 64);
    rd(OFS_DATA, d);
    chk("var9_byte", d, 11'h042);
    rd(OFS_CTRL, d);
    chk("var9_flags", d & 11'h005, 11'h001);
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_shift_tx();
    t_shift_rx();
    t_async_tx();
    t_async_rx();
    t_nine_rx();
    tally_and_finish();
  end
endmodule
`default_nettype wire
